// ==== verilog/tmcs_map.svh ====
// Behaviour
// RL1: ch0/3/4 clear codes 000,100 off; 001 on reg A; 010 on reg B.
// RL2: ch0/3/4 clear code 101 on reg C event, 110 on reg D event.
// RL3: codes 011/111 clear on a synchronised channel's clear, sync bit set.
// RL4: reg C or D as buffer register never clears the counter.
// RL5: ch1/2 clear-select bit 7 reads 0, writes ignored.
// RL6: ch1/2 clear codes 00 off, 01 reg A, 10 reg B, 11 sync.
// RL7: ch0 clock 000 undivided, 100..111 external pins A..D.
// RL8: ch1 clock /1,/4,/16,/64, pin A, pin B, /256, ch2 overflow.
// RL9: ch1/2 phase counting ignores prescaler, counts phase inputs.
// RL10: ch2 clock /1,/4, pin A, pin B, pin C, /1024 (code 111).
// RL11: ch3/4 clock 001 /4, 010 /16, 011 /64, 101 /1024, pins A, B.
// RL12: edge field 00 rising, 01 falling, 1x both; ignored in phase mode.
// RL13: ch0 codes 001..011 take /4, /16, /64.
// RL14: ch3/4 code 000 undivided, code 100 /256.
`ifndef TMCS_MAP_SVH
`define TMCS_MAP_SVH
`define TMCS_REGION_CTRL 3'h0
`define TMCS_REGION_MODE 3'h1
`define TMCS_REGION_SYNC 3'h2
`define TMCS_REGION_COUNT 3'h3
`define TMCS_CLR_RESERVED_BIT 7
`define TMCS_MODE_BUFC_BIT 0
`define TMCS_MODE_BUFD_BIT 1
`define TMCS_MODE_PHASE_BIT 2
`define TMCS_CTRL_RST 8'h00
`define TMCS_MODE_RST 3'h0
`define TMCS_SYNC_RST 5'h00
`define TMCS_COUNT_RST 16'h0000
`define TMCS_COUNT_MAX 16'hffff
`define TMCS_DIV4_BIT 1
`define TMCS_DIV16_BIT 3
`define TMCS_DIV64_BIT 5
`define TMCS_DIV256_BIT 7
`define TMCS_DIV1024_BIT 9
`endif

// ==== verilog/tmcs_pkg.sv ====
package tmcs_pkg;
   typedef struct packed {
      logic [2:0] clr_sel;
      logic [1:0] edge_sel;
      logic [2:0] presc_sel;
   } tmcs_ctrl_t;
   typedef struct packed {
      logic phase;
      logic buf_d;
      logic buf_c;
   } tmcs_mode_t;
   typedef struct packed {
      logic a;
      logic b;
      logic c;
      logic d;
   } tmcs_match_t;
   typedef enum logic [3:0] {
      TMCS_SRC_NONE = 4'h0,
      TMCS_SRC_P1 = 4'h1,
      TMCS_SRC_D4 = 4'h2,
      TMCS_SRC_D16 = 4'h3,
      TMCS_SRC_D64 = 4'h4,
      TMCS_SRC_D256 = 4'h5,
      TMCS_SRC_D1024 = 4'h6,
      TMCS_SRC_PA = 4'h7,
      TMCS_SRC_PB = 4'h8,
      TMCS_SRC_PC = 4'h9,
      TMCS_SRC_PD = 4'ha,
      TMCS_SRC_OVF = 4'hb
   } tmcs_src_t;
   typedef enum logic [1:0] {
      TMCS_BUS_IDLE = 2'b01,
      TMCS_BUS_ACK = 2'b10
   } tmcs_bus_t;
endpackage

// ==== verilog/tmcs_src_sel.sv ====
`timescale 1ns/1ns
`include "tmcs_map.svh"
module tmcs_src_sel #(
   parameter int CH = 0
) (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire tmcs_pkg::tmcs_ctrl_t i_ctrl,
   input wire logic i_phase_mode,
   input wire logic i_phase_tick,
   input wire logic [9:0] i_presc,
   input wire logic [3:0] i_ext_lvl,
   input wire logic i_ovf,
   output logic o_tick
);
   function automatic tmcs_pkg::tmcs_src_t pick(input logic [2:0] c);
      tmcs_pkg::tmcs_src_t s;
      s = tmcs_pkg::TMCS_SRC_NONE;
      if (CH == 0) begin
         case (c)
            3'h0: s = tmcs_pkg::TMCS_SRC_P1; // [RL7]
            3'h1: s = tmcs_pkg::TMCS_SRC_D4; // [RL13]
            3'h2: s = tmcs_pkg::TMCS_SRC_D16; // [RL13]
            3'h3: s = tmcs_pkg::TMCS_SRC_D64; // [RL13]
            3'h4: s = tmcs_pkg::TMCS_SRC_PA; // [RL7]
            3'h5: s = tmcs_pkg::TMCS_SRC_PB; // [RL7]
            3'h6: s = tmcs_pkg::TMCS_SRC_PC; // [RL7]
            default: s = tmcs_pkg::TMCS_SRC_PD; // [RL7]
         endcase
      end else if (CH == 1) begin
         case (c)
            3'h0: s = tmcs_pkg::TMCS_SRC_P1; // [RL8]
            3'h1: s = tmcs_pkg::TMCS_SRC_D4; // [RL8]
            3'h2: s = tmcs_pkg::TMCS_SRC_D16; // [RL8]
            3'h3: s = tmcs_pkg::TMCS_SRC_D64; // [RL8]
            3'h4: s = tmcs_pkg::TMCS_SRC_PA; // [RL8]
            3'h5: s = tmcs_pkg::TMCS_SRC_PB; // [RL8]
            3'h6: s = tmcs_pkg::TMCS_SRC_D256; // [RL8]
            default: s = tmcs_pkg::TMCS_SRC_OVF; // [RL8]
         endcase
      end else if (CH == 2) begin
         // codes 010 and 011 have no source: counter stands still
         case (c)
            3'h0: s = tmcs_pkg::TMCS_SRC_P1; // [RL10]
            3'h1: s = tmcs_pkg::TMCS_SRC_D4; // [RL10]
            3'h4: s = tmcs_pkg::TMCS_SRC_PA; // [RL10]
            3'h5: s = tmcs_pkg::TMCS_SRC_PB; // [RL10]
            3'h6: s = tmcs_pkg::TMCS_SRC_PC; // [RL10]
            3'h7: s = tmcs_pkg::TMCS_SRC_D1024; // [RL10]
            default: s = tmcs_pkg::TMCS_SRC_NONE;
         endcase
      end else begin
         case (c)
            3'h0: s = tmcs_pkg::TMCS_SRC_P1; // [RL14]
            3'h1: s = tmcs_pkg::TMCS_SRC_D4; // [RL11]
            3'h2: s = tmcs_pkg::TMCS_SRC_D16; // [RL11]
            3'h3: s = tmcs_pkg::TMCS_SRC_D64; // [RL11]
            3'h4: s = tmcs_pkg::TMCS_SRC_D256; // [RL14]
            3'h5: s = tmcs_pkg::TMCS_SRC_D1024; // [RL11]
            3'h6: s = tmcs_pkg::TMCS_SRC_PA; // [RL11]
            default: s = tmcs_pkg::TMCS_SRC_PB; // [RL11]
         endcase
      end
      return s;
   endfunction

   tmcs_pkg::tmcs_src_t src;
   logic lvl;
   logic lvl_q;
   logic rise;
   logic fall;
   logic edge_tick;

   assign src = pick(i_ctrl.presc_sel);
   assign lvl =
      (src == tmcs_pkg::TMCS_SRC_D4) ? i_presc[`TMCS_DIV4_BIT] :
      (src == tmcs_pkg::TMCS_SRC_D16) ? i_presc[`TMCS_DIV16_BIT] :
      (src == tmcs_pkg::TMCS_SRC_D64) ? i_presc[`TMCS_DIV64_BIT] :
      (src == tmcs_pkg::TMCS_SRC_D256) ? i_presc[`TMCS_DIV256_BIT] :
      (src == tmcs_pkg::TMCS_SRC_D1024) ? i_presc[`TMCS_DIV1024_BIT] :
      (src == tmcs_pkg::TMCS_SRC_PA) ? i_ext_lvl[0] :
      (src == tmcs_pkg::TMCS_SRC_PB) ? i_ext_lvl[1] :
      (src == tmcs_pkg::TMCS_SRC_PC) ? i_ext_lvl[2] :
      (src == tmcs_pkg::TMCS_SRC_PD) ? i_ext_lvl[3] : 1'b0;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         lvl_q <= 1'b0;
      end else begin
         lvl_q <= lvl;
      end
   end

   assign rise = lvl & ~lvl_q;
   assign fall = ~lvl & lvl_q;
   // a source change may yield one stray edge; change only when stopped
   assign edge_tick = i_ctrl.edge_sel[1] ? (rise | fall) : // [RL12]
                      i_ctrl.edge_sel[0] ? fall : rise; // [RL12]

   // undivided clock and overflow have no edge to choose
   assign o_tick =
      i_phase_mode ? i_phase_tick : // [RL9]
      (src == tmcs_pkg::TMCS_SRC_P1) ? 1'b1 :
      (src == tmcs_pkg::TMCS_SRC_OVF) ? i_ovf :
      (src == tmcs_pkg::TMCS_SRC_NONE) ? 1'b0 : edge_tick;
endmodule

// ==== verilog/tmcs_timer_sel.sv ====
`timescale 1ns/1ns
`include "tmcs_map.svh"
module tmcs_timer_sel (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [3:0] i_ext_clock_pin,
   input wire tmcs_pkg::tmcs_match_t [4:0] i_match,
   input wire logic [1:0] i_phase_tick,
   output logic [4:0] o_count_tick,
   output logic [4:0] o_count_clear,
   output logic o_channel2_overflow
);

   ////////////////////////////////////////////////////////////////////
   // register bus

   tmcs_pkg::tmcs_bus_t bus_q;
   tmcs_pkg::tmcs_bus_t bus_d;
   logic req;
   logic wr_go;
   logic [2:0] region;
   logic [2:0] chan;
   logic chan_ok;
   logic [31:0] rd_word;
   logic [31:0] rdata_q;

   assign req = i_avs_read | i_avs_write;
   assign region = i_avs_address[7:5];
   assign chan = i_avs_address[4:2];
   assign chan_ok = chan < 3'h5;

   always_comb begin
      bus_d = bus_q;
      case (bus_q)
         tmcs_pkg::TMCS_BUS_IDLE: begin
            if (req) begin
               bus_d = tmcs_pkg::TMCS_BUS_ACK;
            end
         end
         tmcs_pkg::TMCS_BUS_ACK: begin
            bus_d = tmcs_pkg::TMCS_BUS_IDLE;
         end
         default: begin
            bus_d = tmcs_pkg::TMCS_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         bus_q <= tmcs_pkg::TMCS_BUS_IDLE;
      end else begin
         bus_q <= bus_d;
      end
   end

   // one wait state lets read data come from a flop
   assign o_avs_waitrequest = req & (bus_q != tmcs_pkg::TMCS_BUS_ACK);
   assign wr_go = i_avs_write & (bus_q == tmcs_pkg::TMCS_BUS_ACK)
                  & i_avs_byteenable[0];

   ////////////////////////////////////////////////////////////////////
   // pin synchroniser and shared prescaler

   logic [3:0] ext_s1_q;
   logic [3:0] ext_s2_q;
   logic [9:0] presc_q;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         ext_s1_q <= 4'h0;
         ext_s2_q <= 4'h0;
         presc_q <= 10'h000;
      end else begin
         ext_s1_q <= i_ext_clock_pin;
         ext_s2_q <= ext_s1_q;
         presc_q <= presc_q + 10'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sync operation register

   logic [4:0] sync_q;
   logic sync_wr;

   assign sync_wr = wr_go & (region == `TMCS_REGION_SYNC)
                    & (chan == 3'h0);

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         sync_q <= `TMCS_SYNC_RST;
      end else if (sync_wr) begin
         sync_q <= i_avs_writedata[4:0];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // per-channel control, selection and count

   tmcs_pkg::tmcs_ctrl_t [4:0] ctrl_q;
   tmcs_pkg::tmcs_mode_t [4:0] mode_q;
   logic [4:0][15:0] count_q;
   logic [4:0] tick;
   logic [4:0] clr_src;
   logic [4:0] clr_sync;
   logic [4:0] clr;
   logic [4:0] tick_q;
   logic [4:0] clr_q;
   logic ovf2;
   logic ovf2_q;

   // only ch2 overflow is flagged; underflow needs the up/down datapath
   assign ovf2 = tick[2] & ~clr[2] & (count_q[2] == `TMCS_COUNT_MAX);

   genvar ch;
   generate
      for (ch = 0; ch < 5; ch++) begin : g_ch
         localparam bit NARROW = (ch == 1) || (ch == 2);
         logic ctrl_wr;
         logic mode_wr;
         logic [2:0] code;
         logic [4:0] others;
         tmcs_pkg::tmcs_ctrl_t ctrl_d;
         tmcs_pkg::tmcs_mode_t mode_d;

         assign ctrl_wr = wr_go & (region == `TMCS_REGION_CTRL)
                          & (chan == 3'(ch));
         assign mode_wr = wr_go & (region == `TMCS_REGION_MODE)
                          & (chan == 3'(ch));
         assign ctrl_d = NARROW ?
            {1'b0, i_avs_writedata[6:0]} : // [RL5]
            i_avs_writedata[7:0];
         // buffer bits exist only on ch0/3/4, phase mode only on ch1/2
         assign mode_d.buf_c = NARROW ? 1'b0 :
            i_avs_writedata[`TMCS_MODE_BUFC_BIT];
         assign mode_d.buf_d = NARROW ? 1'b0 :
            i_avs_writedata[`TMCS_MODE_BUFD_BIT];
         assign mode_d.phase = NARROW ?
            i_avs_writedata[`TMCS_MODE_PHASE_BIT] : 1'b0;

         always_ff @(posedge i_sys_clk) begin
            if (!i_reset_n) begin
               ctrl_q[ch] <= `TMCS_CTRL_RST;
            end else if (ctrl_wr) begin
               ctrl_q[ch] <= ctrl_d;
            end
         end

         always_ff @(posedge i_sys_clk) begin
            if (!i_reset_n) begin
               mode_q[ch] <= `TMCS_MODE_RST;
            end else if (mode_wr) begin
               mode_q[ch] <= mode_d;
            end
         end

         tmcs_src_sel #(
            .CH(ch)
         ) u_src (
            .i_sys_clk(i_sys_clk),
            .i_reset_n(i_reset_n),
            .i_ctrl(ctrl_q[ch]),
            .i_phase_mode(mode_q[ch].phase),
            .i_phase_tick(NARROW ? i_phase_tick[ch == 2] : 1'b0),
            .i_presc(presc_q),
            .i_ext_lvl(ext_s2_q),
            .i_ovf((ch == 1) ? ovf2 : 1'b0),
            .o_tick(tick[ch])
         );

         // bit 7 stored as 0 on ch1/2, so codes fold onto 00..11
         assign code = ctrl_q[ch].clr_sel;
         assign clr_src[ch] =
            (code == 3'h1) ? i_match[ch].a : // [RL1] [RL6]
            (code == 3'h2) ? i_match[ch].b : // [RL1] [RL6]
            (code == 3'h5) ? i_match[ch].c & ~mode_q[ch].buf_c : // [RL2] [RL4]
            (code == 3'h6) ? i_match[ch].d & ~mode_q[ch].buf_d : // [RL2] [RL4]
            1'b0; // [RL1]

         // sync clears come only from match clears, which avoids a loop
         assign others = clr_src & sync_q & ~(5'h01 << ch);
         assign clr_sync[ch] = (code[1:0] == 2'h3) & sync_q[ch]
                               & (|others); // [RL3] [RL6]
         assign clr[ch] = clr_src[ch] | clr_sync[ch];

         always_ff @(posedge i_sys_clk) begin
            if (!i_reset_n) begin
               count_q[ch] <= `TMCS_COUNT_RST;
            end else if (clr[ch]) begin
               count_q[ch] <= `TMCS_COUNT_RST;
            end else if (tick[ch]) begin
               count_q[ch] <= count_q[ch] + 16'h0001;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         tick_q <= 5'h00;
         clr_q <= 5'h00;
         ovf2_q <= 1'b0;
      end else begin
         tick_q <= tick;
         clr_q <= clr;
         ovf2_q <= ovf2;
      end
   end

   assign o_count_tick = tick_q;
   assign o_count_clear = clr_q;
   assign o_channel2_overflow = ovf2_q;

   ////////////////////////////////////////////////////////////////////
   // read data

   logic rd_ctrl;
   logic rd_mode;
   logic rd_sync;
   logic rd_count;
   logic [7:0] ctrl_rd;
   logic [2:0] mode_rd;
   logic [15:0] count_rd;

   assign rd_ctrl = (region == `TMCS_REGION_CTRL) & chan_ok;
   assign rd_mode = (region == `TMCS_REGION_MODE) & chan_ok;
   assign rd_sync = (region == `TMCS_REGION_SYNC) & (chan == 3'h0);
   assign rd_count = (region == `TMCS_REGION_COUNT) & chan_ok;
   assign ctrl_rd = chan_ok ? ctrl_q[chan] : 8'h00;
   assign mode_rd = chan_ok ? mode_q[chan] : 3'h0;
   assign count_rd = chan_ok ? count_q[chan] : 16'h0000;

   // unmapped addresses read zero and ignore writes
   assign rd_word =
      rd_ctrl ? {24'h00_0000, ctrl_rd} :
      rd_mode ? {29'h0000_0000, mode_rd} :
      rd_sync ? {27'h000_0000, sync_q} :
      rd_count ? {16'h0000, count_rd} : 32'h0000_0000;

   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         rdata_q <= 32'h0000_0000;
      end else if (i_avs_read & (bus_q == tmcs_pkg::TMCS_BUS_IDLE)) begin
         rdata_q <= rd_word;
      end
   end

   assign o_avs_readdata = rdata_q;
endmodule

// ==== test/tmcs_sva.sv ====
`timescale 1ns/1ns
module tmcs_sva (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic [7:0] i_avs_address,
   input wire logic i_avs_write,
   input wire logic i_avs_read,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire tmcs_pkg::tmcs_match_t [4:0] i_match,
   input wire logic [1:0] i_phase_tick,
   input wire logic [4:0] o_count_tick,
   input wire logic [4:0] o_count_clear
);
   logic [7:0] ctl_q [5];
   logic [2:0] md_q [5];
   logic [4:0] sy_q;
   logic [3:0] st3_q;
   wire wr_ok = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
   wire [2:0] ch = i_avs_address[4:2];
   wire ctl_wr = wr_ok && i_avs_address[7:5] == 3'h0 && ch < 3'h5;
   wire md_wr = wr_ok && i_avs_address[7:5] == 3'h1 && ch < 3'h5;
   // shadow of the settings keeps every check on the ports alone
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         ctl_q <= '{default: 8'h00};
         md_q <= '{default: 3'h0};
         sy_q <= 5'h00;
      end else begin
         if (ctl_wr) ctl_q[ch] <= i_avs_writedata[7:0];
         if (md_wr) md_q[ch] <= i_avs_writedata[2:0];
         if (wr_ok && i_avs_address[7:2] == 6'h10) begin
            sy_q <= i_avs_writedata[4:0];
         end
      end
   end
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n || (ctl_wr && ch == 3'h3)) begin
         st3_q <= 4'h0;
      end else if (st3_q != 4'hf) begin
         st3_q <= st3_q + 4'h1;
      end
   end
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_reset_n);
   a_clear_on_a: assert property (
      ctl_q[0][7:5] == 3'h1 && i_match[0].a |=> o_count_clear[0])
      else $error("no clear after match a");
   a_clear_off: assert property (
      ctl_q[0][6:5] == 2'h0 |=> !o_count_clear[0])
      else $error("clear while clearing disabled");
   a_clear_on_c: assert property (
      ctl_q[0][7:5] == 3'h5 && i_match[0].c && !md_q[0][0]
      |=> o_count_clear[0]) else $error("no clear after match c");
   a_buf_blocks: assert property (
      ctl_q[0][7:5] == 3'h5 && md_q[0][0] |=> !o_count_clear[0])
      else $error("clear through buffered register c");
   a_sync_follow: assert property (
      ctl_q[4][6:5] == 2'h3 && sy_q[4] && sy_q[0] && ctl_q[0][7:5] == 3'h2
      && i_match[0].b |=> o_count_clear[4])
      else $error("synchronised clear missing");
   a_rsv_bit7: assert property (
      i_avs_read && !o_avs_waitrequest && i_avs_address == 8'h04
      |-> !o_avs_readdata[7]) else $error("reserved bit reads 1");
   a_phase_tick: assert property (
      md_q[1][2] && $past(md_q[1][2]) |=> o_count_clear[1] ||
      o_count_tick[1] == $past(i_phase_tick[0]))
      else $error("phase tick not followed");
   a_p1_every: assert property (
      ctl_q[0][2:0] == 3'h0 && $past(ctl_q[0][2:0]) == 3'h0
      && $past(i_reset_n) |-> o_count_tick[0] || o_count_clear[0])
      else $error("undivided clock missed a cycle");
   a_div4_gap: assert property (
      st3_q == 4'hf && ctl_q[3][4:0] == 5'h01 && o_count_tick[3]
      |=> (!o_count_tick[3] || st3_q < 4'h4) [*3]
      ##1 (o_count_tick[3] || st3_q < 4'h4))
      else $error("divide by four spacing wrong");
endmodule
bind tmcs_timer_sel tmcs_sva u_sva (
   .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n),
   .i_avs_address(i_avs_address), .i_avs_write(i_avs_write),
   .i_avs_read(i_avs_read), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_match(i_match),
   .i_phase_tick(i_phase_tick), .o_count_tick(o_count_tick),
   .o_count_clear(o_count_clear)
);

// ==== test/tmcs_pin_model.sv ====
`timescale 1ns/1ns
module tmcs_pin_model (
   input wire logic i_sys_clk,
   input wire logic i_reset_n,
   input wire logic i_go,
   input wire logic i_slow,
   input wire logic [1:0] i_pin,
   input wire logic [3:0] i_n,
   output logic [3:0] o_ext_clock_pin,
   output logic o_busy
);
   logic [7:0] cnt_q;
   logic [1:0] pin_q;
   logic slow_q;
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         cnt_q <= 8'h00;
         pin_q <= 2'h0;
         slow_q <= 1'b0;
      end else if (i_go) begin
         cnt_q <= i_slow ? {i_n, 4'h0} : {1'b0, i_n, 3'h0};
         pin_q <= i_pin;
         slow_q <= i_slow;
      end else if (o_busy) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end
   // burst of i_n pulses, pins rest low so no edge leaks between bursts
   assign o_busy = cnt_q != 8'h00;
   wire lvl = o_busy & (slow_q ? cnt_q[3] : cnt_q[2]);
   assign o_ext_clock_pin = {3'h0, lvl} << pin_q;
endmodule

// ==== test/tmcs_timer_sel_tb.sv ====
`timescale 1ns/1ns
module tmcs_timer_sel_tb;
   logic i_sys_clk = 1'b0, i_reset_n = 1'b0;
   logic rd = 1'b0, wr = 1'b0, go = 1'b0, slow = 1'b0, mv = 1'b0, p1 = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, rnd;
   logic wreq, busy, ov;
   logic [3:0] pins, nn = 4'h0;
   logic [1:0] ph = 2'h0, pn = 2'h0;
   logic [4:0] tk, cl, sy;
   tmcs_pkg::tmcs_match_t [4:0] mt = '0;
   logic [31:0] rq[$];
   logic [4:0] cq[$];
   logic [7:0] ctl[5];
   logic [2:0] md[5];
   int fail_count = 0, n_compared = 0, cyc = 0, seed = 34, nov = 0;

   always #20 i_sys_clk = ~i_sys_clk;

   tmcs_timer_sel dut (
      .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
      .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_ext_clock_pin(pins), .i_match(mt),
      .i_phase_tick(ph), .o_count_tick(tk), .o_count_clear(cl),
      .o_channel2_overflow(ov)
   );
   tmcs_pin_model u_pins (
      .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_go(go),
      .i_slow(slow), .i_pin(pn), .i_n(nn), .o_ext_clock_pin(pins),
      .o_busy(busy)
   );
////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      adr <= a;
      wdat <= {24'h00_0000, d};
      rd <= !w;
      wr <= w;
      do @(posedge i_sys_clk); while (wreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic wctl(input int c, input logic [7:0] v);
      ctl[c] = (c == 1 || c == 2) ? v & 8'h7f : v;
      bus(1'b1, 8'(c * 4), v);
   endtask
   task automatic wmd(input int c, input logic [2:0] v);
      md[c] = v & ((c == 1 || c == 2) ? 3'h4 : 3'h3);
      bus(1'b1, 8'h20 + 8'(c * 4), {5'h00, v});
   endtask
   task automatic wsy(input logic [4:0] v);
      sy = v;
      bus(1'b1, 8'h40, {3'h0, v});
   endtask
   function automatic logic [4:0] exp_clr(
      input tmcs_pkg::tmcs_match_t [4:0] m);
      logic [4:0] own;
      logic [4:0] e;
      own = 5'h00;
      for (int c = 0; c < 5; c++) begin
         case (ctl[c][7:5])
            3'h1: own[c] = m[c].a;
            3'h2: own[c] = m[c].b;
            3'h5: own[c] = m[c].c & ~md[c][0];
            3'h6: own[c] = m[c].d & ~md[c][1];
            default: own[c] = 1'b0;
         endcase
      end
      e = own;
      for (int c = 0; c < 5; c++) begin
         if (ctl[c][6:5] == 2'h3 && sy[c]
             && |(own & sy & ~(5'h01 << c))) begin
            e[c] = 1'b1;
         end
      end
      return e;
   endfunction
   task automatic pulse(input tmcs_pkg::tmcs_match_t [4:0] m);
      @(posedge i_sys_clk);
      mt <= m;
      mv <= 1'b1;
      cq.push_back(exp_clr(m));
      @(posedge i_sys_clk);
      mt <= '0;
      mv <= 1'b0;
   endtask
   // zero the count with a match, burst the pins, then read the count
   task automatic pin_case(input int c, input logic [4:0] v,
      input logic [1:0] p, input logic [3:0] n, input logic [4:0] e,
      input logic s);
      wctl(c, {3'h1, v});
      pulse(20'h0_0008 << (c * 4));
      @(posedge i_sys_clk);
      pn <= p;
      nn <= n;
      slow <= s;
      go <= 1'b1;
      @(posedge i_sys_clk);
      go <= 1'b0;
      do @(negedge i_sys_clk); while (busy);
      repeat (8) @(posedge i_sys_clk);
      rdx(8'h60 + 8'(c * 4), {27'h000_0000, e});
   endtask
   // whole periods in the window give one tick each, whatever the phase
   task automatic div_case(input int c, input logic [2:0] p, input int w,
      input logic [15:0] e);
      wctl(c, {5'h04, p});
      pulse(20'h0_0008 << (c * 4));
      repeat (w - 1) @(posedge i_sys_clk);
      rdx(8'h60 + 8'(c * 4), {16'h0000, e});
   endtask
////////////////////////////////////////////////////////////////////////////
   always @(posedge i_sys_clk) begin
      if (rd && wreq === 1'b0 && rq.size() > 0) begin
         chk(rdat, rq.pop_front());
      end
      if (p1) begin
         chk(32'(cl), 32'(cq.pop_front()));
      end
      if (ov) begin
         nov++;
         chk(32'(tk[1]), 32'h0000_0001);
      end
      p1 <= mv;
      ph <= 2'($random(seed));
      cyc++;
      if (cyc == 75000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      for (int c = 0; c < 5; c++) begin
         ctl[c] = 8'h00;
         md[c] = 3'h0;
      end
      sy = 5'h00;
      repeat (6) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      for (int c = 0; c < 5; c++) begin
         rdx(8'(c * 4), 32'h0000_0000);
         rdx(8'h20 + 8'(c * 4), 32'h0000_0000);
      end
      rdx(8'h40, 32'h0000_0000);
      rdx(8'h9c, 32'h0000_0000);
      wsy(5'h11);
      wctl(4, 8'h66);
      wctl(0, 8'h44);
      pulse(20'h0_0004);
      for (int k = 0; k < 16; k++) begin
         wctl(0, {k[3:1], 5'h04});
         wctl(1, {k[2:1] == 2'h3, k[2:1], 5'h04});
         wmd(0, {2'h0, k[0]});
         pulse(20'h0_00ff);
      end
      for (int i = 0; i < 60; i++) begin
         rnd = $random(seed);
         wctl(i % 5, rnd[7:0]);
         wmd(i % 5, rnd[10:8]);
         if (rnd[11]) wsy(rnd[16:12]);
         rdx(8'((i % 5) * 4), {24'h00_0000, ctl[i % 5]});
         pulse(rnd[31:12]);
      end
      wmd(1, 3'h0);
      wmd(2, 3'h0);
      pin_case(0, 5'h04, 2'h0, 4'h3, 5'h03, 1'b0);
      pin_case(0, 5'h0f, 2'h3, 4'h3, 5'h03, 1'b1);
      pin_case(0, 5'h16, 2'h2, 4'h2, 5'h04, 1'b0);
      pin_case(1, 5'h04, 2'h0, 4'h3, 5'h03, 1'b0);
      pin_case(1, 5'h05, 2'h1, 4'h2, 5'h02, 1'b1);
      pin_case(2, 5'h06, 2'h2, 4'h3, 5'h03, 1'b0);
      pin_case(2, 5'h04, 2'h1, 4'h3, 5'h00, 1'b0);
      pin_case(3, 5'h07, 2'h1, 4'h3, 5'h03, 1'b0);
      pin_case(4, 5'h06, 2'h0, 4'h2, 5'h02, 1'b1);
      div_case(0, 3'h3, 64, 16'h0001);
      div_case(0, 3'h1, 64, 16'h0010);
      div_case(3, 3'h4, 256, 16'h0001);
      div_case(4, 3'h0, 64, 16'h0040);
      div_case(4, 3'h2, 64, 16'h0004);
      div_case(1, 3'h6, 256, 16'h0001);
      div_case(2, 3'h7, 1024, 16'h0001);
      // ch2 undivided wraps once in the wait, ch1 counts that wrap
      wctl(1, 8'h27);
      wctl(2, 8'h20);
      pulse(20'h0_0880);
      repeat (65540) @(posedge i_sys_clk);
      rdx(8'h64, 32'h0000_0001);
      chk(32'(nov), 32'h0000_0001);
      wctl(3, 8'h01);
      wmd(1, 3'h4);
      repeat (40) @(posedge i_sys_clk);
      give_verdict();
   end
endmodule
